// ### common/adc_seq_pkg.sv
// Notes on behaviour
// - with sync select set, every rising sync edge starts a fresh conversion.
// - five reading modes, each chosen by its own command; sync may start any.
// - idle waits for a start event only: mode command or sync edge.
// - after start, load channel and pointer, then wait the programmable delay.
// - active channel pointer is visible as a 4-bit field.
// - multichannel modes advance the pointer to next enabled channel after conversion.
// - single-channel single and multichannel single return to idle after a reading.
// - continuous modes go back to the update step without a new trigger.
// - multi-pass loops enabled channels until the last enabled one, then idles.
// - sync select clear: command's last falling clock edge starts; sync ignored.
// - end command lets the running conversion finish, then stops.
// - abort command stops at once, dropping the running conversion.
// - single-channel continuous repeats; a new start event restarts it.
// - multi-pass steps enabled channels in ascending order, zero to fifteen.
// - multi-pass start event mid-conversion restarts from first enabled channel.
// - result is shifted out once data valid is high or reading is done.
// - host waits for data valid; result leaves MSB first on rising serial clock.
// - first reading takes fixed overhead of two clocks plus delay plus conversion.
// - later continuous readings have no fixed overhead.
// - one sync pulse drives an unbounded series in continuous modes.
// - multichannel single advances and wraps pointer, then awaits a trigger.
// - multichannel single restart mid-conversion stays on the current channel.
package adc_seq_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int CONV_TIME_NS = 83300;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int FIXED_CYCLES = 2;
    localparam int CNT_BITS = 12;
    localparam logic [CNT_BITS-1:0] CONV_COUNT = CNT_BITS'(CONV_CYCLES - 1);
    localparam logic [CNT_BITS-1:0] FIXED_COUNT = CNT_BITS'(FIXED_CYCLES - 1);
    localparam int CMD_BITS = 8;
    localparam int RESULT_BITS = 24;
    localparam logic [4:0] CMD_LAST_BIT = 5'h07;
    localparam logic [4:0] READ_LAST_BIT = 5'h17;
    localparam logic [4:0] BIT_CNT_MAX = 5'h1F;
    localparam logic [3:0] CMD_CH_GROUP = 4'h0;
    localparam logic [7:0] CMD_SS = 8'h10;
    localparam logic [7:0] start_single_chan_continuous_cmd = 8'h11;
    localparam logic [7:0] start_multi_chan_single_cmd = 8'h12;
    localparam logic [7:0] start_multi_chan_multipass_cmd = 8'h13;
    localparam logic [7:0] start_multi_chan_continuous_cmd = 8'h14;
    localparam logic [7:0] CMD_END = 8'h15;
    localparam logic [7:0] CMD_ABORT = 8'h16;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_DELAY = 2'b11,
        ST_CONV = 2'b10
    } seq_state_e;
    typedef enum logic [2:0] {
        one_chan_one_read_mode = 3'h0,
        one_chan_loop_mode = 3'h1,
        multi_chan_one_read_mode = 3'h2,
        multi_chan_one_pass_mode = 3'h3,
        multi_chan_loop_mode = 3'h4
    } read_mode_e;
endpackage

// ### hw/adc_reading_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module adc_reading_mode_sequencer import adc_seq_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic serialClock,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso,
    output logic misoEnable,
    input wire logic syncPin,
    input wire logic syncSelect,
    input wire logic [15:0] channel_enable_mask,
    input wire logic [CNT_BITS-1:0] delayCycles,
    input wire logic [RESULT_BITS-1:0] convResult,
    output logic data_valid_pin,
    output logic [3:0] active_channel_pointer,
    output logic converting,
    output logic convStart,
    output logic busy
);

    ////////////////////////////////////////////////////////////////
    // helpers

    // next enabled channel above p, wrapping; p itself if it is the only one
    // scan starts one above p, so the current channel is taken last
    // an empty mask returns p itself, but a multichannel start then loads channel 15 through firstEnabled
    function automatic logic [3:0] nextEnabled(input logic [3:0] p, input logic [15:0] m);
        logic [3:0] r;
        logic [3:0] idx;
        logic hit;
        r = p;
        hit = 1'b0;
        for (int i = 1; i <= 16; i++) begin
            idx = p + 4'(i);
            if (!hit && m[idx]) begin
                r = idx;
                hit = 1'b1;
            end
        end
        return r;
    endfunction

    // scan from the top channel, so channel zero is tried first
    function automatic logic [3:0] firstEnabled(input logic [15:0] m);
        return nextEnabled(4'hF, m);
    endfunction

    ////////////////////////////////////////////////////////////////
    // sequencer state, declared ahead of the readout shifter that reads its result

    typedef struct packed {
        seq_state_e state;
        read_mode_e mode;
        logic [3:0] selChan;
        logic [3:0] ptr;
        logic [CNT_BITS-1:0] cnt;
        logic endPend;
        logic dataValid;
        logic convStart;
        logic [RESULT_BITS-1:0] result;
        logic syncMeta;
        logic syncSync;
        logic syncPrev;
        logic cmdMeta;
        logic cmdSync;
        logic cmdPrev;
        logic rdMeta;
        logic rdSync;
        logic rdPrev;
    } seq_s;

    seq_s s;
    seq_s next_s;

    ////////////////////////////////////////////////////////////////
    // link side, serial clock domain
    // only two events leave this domain: a command toggle and a readout toggle
    // each toggle passes a two-flop synchroniser and an edge detector
    // the command code sits in a flop until the next command, so it is
    // stable for several system clocks before its toggle is seen
    // hazard: commands closer than about five system clocks may be lost

    typedef struct packed {
        logic [4:0] bitCnt;
        logic [CMD_BITS-1:0] shiftIn;
    } frame_s;

    typedef struct packed {
        logic [CMD_BITS-1:0] cmdCode;
        logic cmdToggle;
        logic readToggle;
    } link_s;

    typedef struct packed {
        logic loaded;
        logic [RESULT_BITS-1:0] outBits;
    } shout_s;

    frame_s f;
    frame_s next_f;
    link_s l;
    link_s next_l;
    shout_s o;
    shout_s next_o;
    logic frameResetN;

    // frame reset is combinational: a glitch on chip select ends the frame early
    // a raised chip select clears the frame even with the serial clock stopped
    assign frameResetN = resetn & ~chip_select_n;

    // bits past the eighth still shift but no longer form a command
    // command bits sampled on falling edges
    always_comb begin
        next_f = f;
        next_l = l;
        next_f.shiftIn = {f.shiftIn[CMD_BITS-2:0], mosi};
        if (f.bitCnt != BIT_CNT_MAX) begin
            next_f.bitCnt = f.bitCnt + 5'h01;
        end
        if (f.bitCnt == CMD_LAST_BIT) begin
            next_l.cmdCode = {f.shiftIn[CMD_BITS-2:0], mosi};
            next_l.cmdToggle = ~l.cmdToggle;
        end
        if (f.bitCnt == READ_LAST_BIT) begin
            next_l.readToggle = ~l.readToggle;
        end
    end

    always_ff @(negedge serialClock or negedge frameResetN) begin
        if (!frameResetN) begin
            f <= '0;
        end else begin
            f <= next_f;
        end
    end

    // held across frames, so only the global reset clears it
    always_ff @(negedge serialClock or negedge resetn) begin
        if (!resetn) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    // the result word crosses without a synchroniser: it only changes on a
    // completion, and a host that waits for data valid reads a settled word
    // limitation: a readout that spans a completion returns the older result, loaded on its first rising edge
    // result shifter; the result word is quasi-static while data valid is high
    always_comb begin
        next_o = o;
        if (!o.loaded) begin
            next_o.loaded = 1'b1;
            next_o.outBits = s.result;
        end else begin
            next_o.outBits = {o.outBits[RESULT_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge serialClock or negedge frameResetN) begin
        if (!frameResetN) begin
            o <= '0;
        end else begin
            o <= next_o;
        end
    end

    // miso is zero outside a frame, so a released line never shows a stale bit
    // result on serial out
    assign miso = o.outBits[RESULT_BITS-1];
    assign misoEnable = ~chip_select_n;

    ////////////////////////////////////////////////////////////////
    // sequencer, system clock domain
    // path: idle, load, delay, convert, then idle or back to delay
    // a start event in any state restarts through load
    // the delay count is read from its port on entry to delay only

    always_comb begin
        logic syncRise;
        logic cmdEvt;
        logic isMode;
        logic startEvt;
        logic [3:0] startPtr;
        logic [3:0] nxt;
        read_mode_e newMode;
        syncRise = 1'b0;
        cmdEvt = 1'b0;
        isMode = 1'b0;
        startEvt = 1'b0;
        startPtr = 4'h0;
        nxt = 4'h0;
        newMode = s.mode;
        next_s = s;
        next_s.convStart = 1'b0;

        // sync select comes from this clock, so only the pin is synchronised
        // two-stage synchronisers, edges taken past the second stage
        next_s.syncMeta = syncPin;
        next_s.syncSync = s.syncMeta;
        next_s.syncPrev = s.syncSync;
        next_s.cmdMeta = l.cmdToggle;
        next_s.cmdSync = s.cmdMeta;
        next_s.cmdPrev = s.cmdSync;
        next_s.rdMeta = l.readToggle;
        next_s.rdSync = s.rdMeta;
        next_s.rdPrev = s.rdSync;
        // pulse of two clocks survives the synchroniser
        syncRise = s.syncSync & ~s.syncPrev;
        cmdEvt = s.cmdSync ^ s.cmdPrev;

        // a mode command always sets the mode; it starts a run only with sync select clear
        // mode commands
        if (cmdEvt) begin
            isMode = 1'b1;
            case (l.cmdCode)
                CMD_SS: newMode = one_chan_one_read_mode;
                start_single_chan_continuous_cmd: newMode = one_chan_loop_mode;
                start_multi_chan_single_cmd: newMode = multi_chan_one_read_mode;
                start_multi_chan_multipass_cmd: newMode = multi_chan_one_pass_mode;
                start_multi_chan_continuous_cmd: newMode = multi_chan_loop_mode;
                default: isMode = 1'b0;
            endcase
            if (l.cmdCode[7:4] == CMD_CH_GROUP) begin
                next_s.selChan = l.cmdCode[3:0];
            end
        end
        next_s.mode = newMode;

        startEvt = syncSelect ? syncRise : isMode;

        // start channel: the selected one for single-channel modes, else from the mask
        // current channel kept
        case (newMode)
            one_chan_one_read_mode: startPtr = next_s.selChan;
            one_chan_loop_mode: startPtr = next_s.selChan;
            multi_chan_one_read_mode: startPtr = channel_enable_mask[s.ptr] ? s.ptr
                                                 : firstEnabled(channel_enable_mask);
            default: startPtr = firstEnabled(channel_enable_mask);
        endcase
        nxt = nextEnabled(s.ptr, channel_enable_mask);

        // load costs two clocks, delay its programmed count plus one, convert the
        // full conversion count; repeats skip load and go straight to delay
        case (s.state)
            ST_IDLE: begin
                next_s.endPend = 1'b0;
            end
            ST_LOAD: begin
                if (s.cnt == '0) begin
                    next_s.state = ST_DELAY;
                    next_s.cnt = delayCycles;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            ST_DELAY: begin
                if (s.cnt == '0) begin
                    next_s.state = ST_CONV;
                    next_s.cnt = CONV_COUNT;
                    next_s.convStart = 1'b1;
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            // result captured on the last conversion cycle
            ST_CONV: begin
                if (s.cnt == '0) begin
                    next_s.result = convResult;
                    next_s.dataValid = 1'b1;
                    next_s.cnt = delayCycles;
                    // single-channel modes keep the selected channel
                    // advance pointer
                    if (s.mode == multi_chan_one_read_mode || s.mode == multi_chan_one_pass_mode ||
                        s.mode == multi_chan_loop_mode) begin
                        next_s.ptr = nxt;
                    end
                    next_s.state = ST_DELAY;
                    case (s.mode)
                        one_chan_one_read_mode: next_s.state = ST_IDLE;
                        multi_chan_one_read_mode: next_s.state = ST_IDLE;
                        // a wrap below or onto the current channel ends the pass
                        // stop after last enabled
                        multi_chan_one_pass_mode: begin
                            if (nxt <= s.ptr) begin
                                next_s.state = ST_IDLE;
                            end
                        end
                        default: next_s.state = ST_DELAY;
                    endcase
                    if (s.endPend) begin
                        next_s.state = ST_IDLE;
                    end
                end else begin
                    next_s.cnt = s.cnt - 1'b1;
                end
            end
            default: next_s.state = ST_IDLE;
        endcase

        // the readout edge clears data valid two to three clocks after the last bit
        // readout clears, a completion in the same cycle wins
        if ((s.rdSync ^ s.rdPrev) && !(s.state == ST_CONV && s.cnt == '0)) begin
            next_s.dataValid = 1'b0;
        end
        if (next_s.convStart) begin
            next_s.dataValid = 1'b0;
        end

        // a start event overrides the state case above: a run in progress is
        // dropped and the fixed overhead is counted again
        // restart on start event
        if (startEvt) begin
            next_s.state = ST_LOAD;
            next_s.cnt = FIXED_COUNT;
            next_s.ptr = startPtr;
            next_s.endPend = 1'b0;
            next_s.convStart = 1'b0;
        end

        // end and abort come last; abort, and end outside a conversion, win over a start in the same cycle
        if (cmdEvt && l.cmdCode == CMD_END) begin
            if (s.state == ST_CONV) begin
                next_s.endPend = 1'b1;
            end else begin
                next_s.state = ST_IDLE;
                next_s.convStart = 1'b0;
            end
        end
        if (cmdEvt && l.cmdCode == CMD_ABORT) begin
            next_s.state = ST_IDLE;
            next_s.endPend = 1'b0;
            next_s.convStart = 1'b0;
        end
    end

    // asynchronous reset to idle; every field clears together
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // busy covers load and delay too, so a host can tell a run is pending
    // status outputs, all from flops
    assign data_valid_pin = s.dataValid;
    assign active_channel_pointer = s.ptr;
    assign converting = (s.state == ST_CONV);
    assign convStart = s.convStart;
    assign busy = (s.state != ST_IDLE);

endmodule // adc_reading_mode_sequencer
`default_nettype wire

// ### tb/adc_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker import adc_seq_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic chip_select_n,
    input wire logic miso,
    input wire logic misoEnable,
    input wire logic syncPin,
    input wire logic syncSelect,
    input wire logic [CNT_BITS-1:0] delayCycles,
    input wire logic data_valid_pin,
    input wire logic converting,
    input wire logic convStart,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    int convCnt;
    int leadCnt;
////////////////////////////////
    // run lengths; leaving a counted phase zeroes them, but a restart in load or delay keeps the lead count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            convCnt <= 0;
            leadCnt <= 0;
        end else begin
            convCnt <= converting ? convCnt + 1 : 0;
            leadCnt <= (busy && !converting) ? leadCnt + 1 : 0;
        end
    end
////////////////////////////////
    property p_start_pulse;
        convStart |-> converting ##1 !convStart;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start pulse wrong");
    property p_start_marks;
        $rose(converting) |-> convStart;
    endproperty
    a_start_marks: assert property (p_start_marks)
        else $error("conversion began unmarked");
    property p_conv_len;
        $rose(data_valid_pin) |-> convCnt == CONV_CYCLES && $fell(converting);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length wrong");
    // first reading carries the fixed overhead, later ones none
    property p_lead_in;
        $rose(converting) |-> leadCnt >= delayCycles + 1 && leadCnt <= delayCycles + 4;
    endproperty
    a_lead_in: assert property (p_lead_in)
        else $error("delay before conversion wrong");
    property p_valid_clear;
        convStart |=> !data_valid_pin;
    endproperty
    a_valid_clear: assert property (p_valid_clear)
        else $error("data valid not cleared");
    property p_sync;
        $rose(busy) && syncSelect |-> $past(syncPin, 2) || $past(syncPin, 3);
    endproperty
    a_sync: assert property (p_sync)
        else $error("start without sync edge");
    property p_idle;
        !busy |-> !converting && !convStart;
    endproperty
    a_idle: assert property (p_idle)
        else $error("converting while idle");
    property p_miso_idle;
        chip_select_n |-> !miso && !misoEnable;
    endproperty
    a_miso_idle: assert property (p_miso_idle)
        else $error("miso driven outside frame");
endmodule // adc_seq_checker
bind adc_reading_mode_sequencer adc_seq_checker u_adc_seq_checker (.clock, .resetn, .chip_select_n, .miso,
    .misoEnable, .syncPin, .syncSelect, .delayCycles, .data_valid_pin, .converting, .convStart, .busy);
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic serialClock,
    output logic chip_select_n,
    output logic mosi,
    output logic syncPin,
    input wire logic miso
);
    // link clock stands still between frames
    initial begin
        serialClock = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b1;
        syncPin = 1'b0;
    end
////////////////////////////////
    // one command per frame, msb first, 32 ns link period
    task automatic sendCmd(input logic [7:0] code);
        chip_select_n = 1'b0;
        // data moves mid low phase, clear of the falling sampling edge
        for (int i = 7; i >= 0; i--) begin
            #8 mosi = code[i];
            #8 serialClock = 1'b1;
            #16 serialClock = 1'b0;
        end
        #16 chip_select_n = 1'b1;
        mosi = ~mosi; // released line shows no stale bit
        #200;
    endtask
    task automatic readWord(output logic [23:0] word);
        mosi = 1'b1; // first byte then reads as an unused code
        chip_select_n = 1'b0;
        #16;
        for (int i = 23; i >= 0; i--) begin
            serialClock = 1'b1;
            #16 word[i] = miso;
            serialClock = 1'b0;
            #16;
        end
        chip_select_n = 1'b1;
        #200;
    endtask
    task automatic pulseSync();
        syncPin = 1'b1;
        #120 syncPin = 1'b0;
        #120;
    endtask
endmodule // host_model
`default_nettype wire

// ### tb/test_adc_reading_mode_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_reading_mode_sequencer import adc_seq_pkg::*;;
    localparam logic [CNT_BITS-1:0] DLY = 12'h005;
    localparam logic [23:0] RES = 24'hC35A96;
    logic clock = 1'b0;
    logic resetn, serialClock, chip_select_n, mosi, miso, misoEnable, syncPin, syncSelect;
    logic data_valid_pin, converting, convStart, busy;
    logic [15:0] channel_enable_mask;
    logic [CNT_BITS-1:0] delayCycles;
    logic [RESULT_BITS-1:0] convResult;
    logic [3:0] active_channel_pointer;
    int fail_count = 0;
    int comparisons = 0;
    always #20 clock = ~clock;
    adc_reading_mode_sequencer u_adc_reading_mode_sequencer (.clock, .resetn, .serialClock, .chip_select_n,
        .mosi, .miso, .misoEnable, .syncPin, .syncSelect, .channel_enable_mask, .delayCycles, .convResult,
        .data_valid_pin, .active_channel_pointer, .converting, .convStart, .busy);
    host_model u_host_model (.serialClock, .chip_select_n, .mosi, .syncPin, .miso);
////////////////////////////////
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic checkValue(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for start pulse (0) or data valid (1); n counts clocks
    task automatic waitOn(input int sel, output int n);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (hit !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            hit = sel ? data_valid_pin : convStart;
            if (n > 3000) begin
                fail_count++;
                $display("unexpected timeout on wait %0d", sel);
                tally_and_finish();
            end
        end
    endtask
////////////////////////////////
    task automatic scenSingle();
        int n;
        logic [23:0] w;
        @(negedge clock);
        u_host_model.pulseSync();
        checkValue("busy", 24'h0, 24'(busy));
        u_host_model.sendCmd(8'h03);
        u_host_model.sendCmd(CMD_SS);
        waitOn(0, n);
        checkValue("pointer", 24'h3, 24'(active_channel_pointer));
        waitOn(1, n);
        checkValue("length", 24'(CONV_CYCLES), 24'(n));
        checkValue("busy", 24'h0, 24'(busy));
        u_host_model.readWord(w);
        checkValue("result", RES, w);
        checkValue("valid", 24'h0, 24'(data_valid_pin));
    endtask
    task automatic scenPass();
        int n;
        logic [3:0] order [3] = '{4'h0, 4'h4, 4'hC};
        @(negedge clock);
        channel_enable_mask = 16'h1011;
        u_host_model.sendCmd(8'h00);
        u_host_model.sendCmd(start_multi_chan_multipass_cmd);
        for (int i = 0; i < 3; i++) begin
            waitOn(0, n);
            checkValue("pointer", 24'(order[i]), 24'(active_channel_pointer));
            if (i > 0) begin
                checkValue("period", 24'(CONV_CYCLES + DLY + 1), 24'(n));
            end
        end
        waitOn(1, n);
        checkValue("busy", 24'h0, 24'(busy));
    endtask
    task automatic scenLoop();
        int n;
        @(negedge clock);
        syncSelect = 1'b1;
        u_host_model.sendCmd(8'h05);
        u_host_model.sendCmd(start_single_chan_continuous_cmd);
        checkValue("busy", 24'h0, 24'(busy));
        @(negedge clock);
        u_host_model.pulseSync();
        waitOn(0, n);
        checkValue("pointer", 24'h5, 24'(active_channel_pointer));
        waitOn(0, n);
        checkValue("period", 24'(CONV_CYCLES + DLY + 1), 24'(n));
        u_host_model.sendCmd(CMD_END);
        waitOn(1, n);
        checkValue("busy", 24'h0, 24'(busy));
        @(negedge clock);
        syncSelect = 1'b0;
    endtask
    task automatic scenAbort();
        int n;
        u_host_model.sendCmd(8'h00);
        u_host_model.sendCmd(start_multi_chan_continuous_cmd);
        waitOn(0, n);
        waitOn(0, n);
        checkValue("pointer", 24'h4, 24'(active_channel_pointer));
        u_host_model.sendCmd(start_multi_chan_continuous_cmd);
        waitOn(0, n);
        checkValue("pointer", 24'h0, 24'(active_channel_pointer));
        u_host_model.sendCmd(CMD_ABORT);
        repeat (3) @(posedge clock);
        #1;
        checkValue("busy", 24'h0, 24'(busy));
        checkValue("valid", 24'h0, 24'(data_valid_pin));
    endtask
    // multichannel single: advance after a reading, restart keeps the channel
    task automatic scenMulti();
        int n;
        @(negedge clock);
        u_host_model.sendCmd(start_multi_chan_single_cmd);
        waitOn(0, n);
        checkValue("pointer", 24'h0, 24'(active_channel_pointer));
        waitOn(1, n);
        checkValue("busy", 24'h0, 24'(busy));
        checkValue("pointer", 24'h4, 24'(active_channel_pointer));
        u_host_model.sendCmd(start_multi_chan_single_cmd);
        waitOn(0, n);
        u_host_model.sendCmd(start_multi_chan_single_cmd);
        waitOn(0, n);
        checkValue("pointer", 24'h4, 24'(active_channel_pointer));
        u_host_model.sendCmd(CMD_ABORT);
        repeat (3) @(posedge clock);
        #1;
        checkValue("busy", 24'h0, 24'(busy));
    endtask
////////////////////////////////
    // reset for 8 clocks, inputs move on the falling edge
    initial begin
        resetn = 1'b0;
        syncSelect = 1'b0;
        channel_enable_mask = 16'h0008;
        delayCycles = DLY;
        convResult = RES;
        repeat (8) @(posedge clock);
        @(negedge clock);
        resetn = 1'b1;
        scenSingle();
        scenPass();
        scenLoop();
        scenAbort();
        scenMulti();
        tally_and_finish();
    end
endmodule // test_adc_reading_mode_sequencer
`default_nettype wire
